// ### src/tcd_dma.sv
// Three-channel DMA controller: arbiter, structure fetch and AHB master engine.
//
// Operation
// - Three channels take requests; an arbiter picks among pending channels.
// - Channel structures live in a separate 1K configuration SRAM.
// - Two priority levels; lower channel index wins at equal priority.
// - Word, halfword or byte elements; addresses step by size or stay fixed.
// - Element count is the stored count-minus-one plus one, 1 to 1024.
// - Memory-to-memory, memory-to-peripheral and peripheral-to-memory moves.
// - Above two to the arbitration power, pause after that many and await request.
// - Per-channel interrupt enable, completion flag and error flag.
// - Bus error sets error flag, raises interrupt if enabled, clears enable.
// - Destination writes use the source element width.
// - Byte and halfword writes repeat the value on all unused lanes.
// - Cycle-control field selects one of eight modes.
// - Invalid mode moves nothing and clears the channel enable.
// - Basic mode moves the smaller of remaining count and burst size.
// - After a pause higher priority goes first, then this channel resumes.
// - Basic completion sets flag, clears enable, zeroes count and cycle fields.
// - Ping-pong alternates structures; stops on invalid structure or disable.
// - Scatter-gather primary loads the backup structure from a list in SRAM.
// - Auto-request re-requests itself after each pause, then clears enable.
// - Completion pulses the channel done output for one clock cycle.
`timescale 1ns/100ps
`default_nettype none

module tcd_dma (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Channel control and status.
    input wire logic [2:0] chan_en_set_in,
    input wire logic [2:0] prio_high_in,
    input wire logic [2:0] int_en_in,
    input wire logic [2:0] periph_req_in,
    input wire logic [2:0] sw_req_in,
    input wire logic [2:0] alt_clr_in,
    input wire logic [2:0] done_clr_in,
    input wire logic [2:0] err_clr_in,
    output logic [2:0] chan_en_out,
    output logic [2:0] alt_out,
    output logic [2:0] channel_complete_flag_out,
    output logic [2:0] err_flag_out,
    output logic [2:0] done_pulse_out,
    output logic [2:0] irq_done_out,
    output logic [2:0] irq_err_out,
    // Configuration SRAM port, read data one cycle after the address.
    output logic [7:0] cfg_addr_out,
    output logic cfg_we_out,
    output logic [31:0] cfg_wdata_out,
    input wire logic [31:0] cfg_rdata_in,
    // AHB master.
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out,
    input wire logic [31:0] hrdata_in,
    input wire logic hready_in,
    input wire logic hresp_in
);

    // ==========================================================
    // Helper functions
    // ==========================================================
    function automatic logic [1:0] pick(input logic [2:0] c, input logic [2:0] hi);
        logic [2:0] m;
        pick = 2'h0;
        m = (|(c & hi)) ? (c & hi) : c;
        for (int i = tcd_pkg::CH_NUM - 1; i >= 0; i--) begin
            if (m[i]) begin
                pick = 2'(i);
            end
        end
    endfunction : pick

    function automatic logic [7:0] sbase(input logic alt, input logic [1:0] ch);
        sbase = (alt ? tcd_pkg::CFG_ALT_BASE : tcd_pkg::CFG_PRI_BASE)
            + 8'(8'(ch) * tcd_pkg::CFG_STRIDE);
    endfunction : sbase

    function automatic logic [31:0] eaddr(input logic [31:0] p, input logic [10:0] n,
                                          input logic [1:0] inc);
        eaddr = (inc == tcd_pkg::INC_NONE) ? p : p + (32'(n) << inc);
    endfunction : eaddr

    function automatic logic [31:0] lane(input logic [31:0] d, input logic [1:0] a,
                                         input logic [1:0] sz);
        logic [31:0] s;
        s = d >> {a, 3'h0};
        unique case (sz)
            tcd_pkg::SZ_BYTE: lane = {24'h0, s[7:0]};
            tcd_pkg::SZ_HALF: lane = {16'h0, s[15:0]};
            default: lane = d;
        endcase
    endfunction : lane

    function automatic logic [31:0] repl(input logic [31:0] d, input logic [1:0] sz);
        unique case (sz)
            tcd_pkg::SZ_BYTE: repl = {4{d[7:0]}};
            tcd_pkg::SZ_HALF: repl = {2{d[15:0]}};
            default: repl = d;
        endcase
    endfunction : repl

    // ==========================================================
    // State
    // ==========================================================
    tcd_pkg::tcd_state_e state_reg;
    logic [1:0] cur_reg;
    logic [2:0] fidx_reg;
    logic [31:0] src_reg;
    logic [31:0] dst_reg;
    logic [31:0] ctl_reg;
    logic [10:0] burst_reg;
    logic wr_phase_reg;
    logic [10:0] cnt_reg [tcd_pkg::CH_NUM];
    logic [2:0] en_reg;
    logic [2:0] pend_reg;
    logic [2:0] alt_reg;
    logic [2:0] dflag_reg;
    logic [2:0] eflag_reg;
    logic [2:0] grant_reg;
    logic [2:0] hw_dis_reg;
    logic [2:0] done_pls_reg;
    logic [2:0] err_pls_reg;
    logic [2:0] self_req_reg;
    logic [2:0] alt_tgl_reg;

    logic [2:0] cc;
    logic [1:0] ssz;
    logic [3:0] rp;
    logic [10:0] n_elems;
    logic [10:0] cap;
    logic [10:0] remain;
    logic [10:0] limit;
    logic [10:0] cnt_nx;
    logic [10:0] burst_nx;
    logic [2:0] cand;
    logic [2:0] cur_hot;
    logic sg_pri;
    logic [31:0] dst_addr;

    assign cc = ctl_reg[tcd_pkg::CC_LSB +: 3];
    assign ssz = ctl_reg[tcd_pkg::SSZ_LSB +: 2];
    assign rp = ctl_reg[tcd_pkg::RP_LSB +: 4];
    assign n_elems = {1'b0, ctl_reg[tcd_pkg::NM1_LSB +: 10]} + tcd_pkg::CNT_ONE;
    assign cap = (rp >= tcd_pkg::RP_MAX) ? tcd_pkg::CNT_MAX : (tcd_pkg::CNT_ONE << rp);
    assign remain = n_elems - cnt_reg[cur_reg] + burst_reg;
    assign limit = (remain < cap) ? remain : cap;
    assign cnt_nx = cnt_reg[cur_reg] + tcd_pkg::CNT_ONE;
    assign burst_nx = burst_reg + tcd_pkg::CNT_ONE;
    assign cand = pend_reg & en_reg & ~hw_dis_reg;
    assign cur_hot = 3'h1 << cur_reg;
    assign sg_pri = (cc == tcd_pkg::CC_MSG_PRI) || (cc == tcd_pkg::CC_PSG_PRI);
    assign dst_addr = eaddr(dst_reg, cnt_reg[cur_reg], ctl_reg[tcd_pkg::DINC_LSB +: 2]);

    // ==========================================================
    // Transfer engine
    // ==========================================================
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= tcd_pkg::TCD_IDLE;
            cur_reg <= 2'h0;
            fidx_reg <= 3'h0;
            src_reg <= 32'h0;
            dst_reg <= 32'h0;
            ctl_reg <= 32'h0;
            burst_reg <= 11'h0;
            wr_phase_reg <= 1'b0;
            for (int i = 0; i < tcd_pkg::CH_NUM; i++) begin
                cnt_reg[i] <= 11'h0;
            end
            grant_reg <= 3'h0;
            hw_dis_reg <= 3'h0;
            done_pls_reg <= 3'h0;
            err_pls_reg <= 3'h0;
            self_req_reg <= 3'h0;
            alt_tgl_reg <= 3'h0;
            cfg_addr_out <= 8'h0;
            cfg_we_out <= 1'b0;
            cfg_wdata_out <= 32'h0;
            haddr_out <= 32'h0;
            htrans_out <= tcd_pkg::HTRANS_IDLE;
            hwrite_out <= 1'b0;
            hsize_out <= 3'h0;
            hwdata_out <= 32'h0;
        end else begin
            grant_reg <= 3'h0;
            hw_dis_reg <= 3'h0;
            done_pls_reg <= 3'h0;
            err_pls_reg <= 3'h0;
            self_req_reg <= 3'h0;
            alt_tgl_reg <= 3'h0;
            cfg_we_out <= 1'b0;
            unique case (state_reg)
                tcd_pkg::TCD_IDLE: begin
                    if (|cand) begin
                        cur_reg <= pick(cand, prio_high_in);
                        grant_reg <= 3'h1 << pick(cand, prio_high_in);
                        fidx_reg <= 3'h0;
                        burst_reg <= 11'h0;
                        state_reg <= tcd_pkg::TCD_FETCH;
                    end
                end
                tcd_pkg::TCD_FETCH: begin
                    cfg_addr_out <= sbase(alt_reg[cur_reg], cur_reg) + {5'h0, fidx_reg};
                    if (fidx_reg == tcd_pkg::W_SRC + tcd_pkg::FETCH_LAG) begin
                        src_reg <= cfg_rdata_in;
                    end
                    if (fidx_reg == tcd_pkg::W_DST + tcd_pkg::FETCH_LAG) begin
                        dst_reg <= cfg_rdata_in;
                    end
                    if (fidx_reg == tcd_pkg::W_CTL + tcd_pkg::FETCH_LAG) begin
                        ctl_reg <= cfg_rdata_in;
                        state_reg <= tcd_pkg::TCD_ISSUE;
                    end
                    fidx_reg <= fidx_reg + 3'h1;
                end
                tcd_pkg::TCD_ISSUE: begin
                    if (cc == tcd_pkg::CC_INVALID) begin
                        hw_dis_reg <= cur_hot;
                        cnt_reg[cur_reg] <= 11'h0;
                        state_reg <= tcd_pkg::TCD_IDLE;
                    end else begin
                        haddr_out <= eaddr(src_reg, cnt_reg[cur_reg],
                                           ctl_reg[tcd_pkg::SINC_LSB +: 2]);
                        htrans_out <= tcd_pkg::HTRANS_NONSEQ;
                        hwrite_out <= 1'b0;
                        hsize_out <= {1'b0, ssz};
                        wr_phase_reg <= 1'b0;
                        state_reg <= tcd_pkg::TCD_APH;
                    end
                end
                tcd_pkg::TCD_APH: begin
                    if (hready_in) begin
                        htrans_out <= tcd_pkg::HTRANS_IDLE;
                        state_reg <= tcd_pkg::TCD_DPH;
                    end
                end
                tcd_pkg::TCD_DPH: begin
                    if (hresp_in) begin
                        err_pls_reg <= cur_hot;
                        hw_dis_reg <= cur_hot;
                        cnt_reg[cur_reg] <= 11'h0;
                        state_reg <= tcd_pkg::TCD_IDLE;
                    end else if (hready_in && wr_phase_reg) begin
                        state_reg <= tcd_pkg::TCD_STEP;
                    end else if (hready_in && sg_pri) begin
                        cfg_addr_out <= dst_addr[2 +: tcd_pkg::CFG_AW];
                        cfg_wdata_out <= hrdata_in;
                        cfg_we_out <= 1'b1;
                        state_reg <= tcd_pkg::TCD_STEP;
                    end else if (hready_in) begin
                        haddr_out <= dst_addr;
                        htrans_out <= tcd_pkg::HTRANS_NONSEQ;
                        hwrite_out <= 1'b1;
                        hsize_out <= {1'b0, ssz};
                        hwdata_out <= repl(lane(hrdata_in, haddr_out[1:0], ssz), ssz);
                        wr_phase_reg <= 1'b1;
                        state_reg <= tcd_pkg::TCD_APH;
                    end
                end
                tcd_pkg::TCD_STEP: begin
                    hwrite_out <= 1'b0;
                    burst_reg <= burst_nx;
                    if (cnt_nx == n_elems) begin
                        cnt_reg[cur_reg] <= 11'h0;
                        state_reg <= tcd_pkg::TCD_IDLE;
                        unique case (cc)
                            tcd_pkg::CC_BASIC, tcd_pkg::CC_AUTO: begin
                                done_pls_reg <= cur_hot;
                                state_reg <= tcd_pkg::TCD_WBACK;
                            end
                            tcd_pkg::CC_PINGPONG: begin
                                done_pls_reg <= cur_hot;
                                alt_tgl_reg <= cur_hot;
                            end
                            tcd_pkg::CC_MSG_PRI, tcd_pkg::CC_MSG_ALT: begin
                                alt_tgl_reg <= cur_hot;
                                self_req_reg <= cur_hot;
                            end
                            default: begin
                                alt_tgl_reg <= cur_hot;
                            end
                        endcase
                    end else if (burst_nx == limit) begin
                        cnt_reg[cur_reg] <= cnt_nx;
                        state_reg <= tcd_pkg::TCD_IDLE;
                        if (cc == tcd_pkg::CC_AUTO || cc == tcd_pkg::CC_MSG_PRI
                            || cc == tcd_pkg::CC_MSG_ALT) begin
                            self_req_reg <= cur_hot;
                        end
                    end else begin
                        cnt_reg[cur_reg] <= cnt_nx;
                        state_reg <= tcd_pkg::TCD_ISSUE;
                    end
                end
                tcd_pkg::TCD_WBACK: begin
                    cfg_addr_out <= sbase(alt_reg[cur_reg], cur_reg) + {5'h0, tcd_pkg::W_CTL};
                    cfg_wdata_out <= ctl_reg & ~tcd_pkg::CTL_CLR_MASK;
                    cfg_we_out <= 1'b1;
                    hw_dis_reg <= cur_hot;
                    state_reg <= tcd_pkg::TCD_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Per-channel enables, requests, structure select and flags
    // ==========================================================
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            en_reg <= 3'h0;
        end else begin
            en_reg <= (en_reg & ~hw_dis_reg) | chan_en_set_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_reg <= 3'h0;
        end else begin
            pend_reg <= ((pend_reg & ~grant_reg) | periph_req_in | sw_req_in | self_req_reg)
                & en_reg;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alt_reg <= 3'h0;
        end else begin
            alt_reg <= (alt_reg & ~alt_clr_in) ^ alt_tgl_reg;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dflag_reg <= 3'h0;
            eflag_reg <= 3'h0;
        end else begin
            dflag_reg <= (dflag_reg & ~done_clr_in) | done_pls_reg;
            eflag_reg <= (eflag_reg & ~err_clr_in) | err_pls_reg;
        end
    end

    assign chan_en_out = en_reg;
    assign alt_out = alt_reg;
    assign channel_complete_flag_out = dflag_reg;
    assign err_flag_out = eflag_reg;
    assign done_pulse_out = done_pls_reg;
    assign irq_done_out = dflag_reg & int_en_in;
    assign irq_err_out = eflag_reg & int_en_in;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_done_one_cycle;
        @(posedge clk_in) disable iff (rst_in)
        (done_pls_reg != 3'h0) |=> (done_pls_reg == 3'h0) [*2];
    endproperty
    a_done_one_cycle: assert property (p_done_one_cycle)
        else $error("Done pulse lasted more than one cycle.");

    property p_done_sets_flag;
        @(posedge clk_in) disable iff (rst_in)
        (done_pls_reg != 3'h0) |=> ((dflag_reg & $past(done_pls_reg)) == $past(done_pls_reg));
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag)
        else $error("Completion did not set the completion flag.");

    property p_err_disables;
        @(posedge clk_in) disable iff (rst_in)
        (err_pls_reg != 3'h0 && chan_en_set_in == 3'h0)
            |=> ((en_reg & $past(err_pls_reg)) == 3'h0)
                && ((eflag_reg & $past(err_pls_reg)) != 3'h0);
    endproperty
    a_err_disables: assert property (p_err_disables)
        else $error("Bus error did not flag and disable the channel.");

    property p_invalid_no_move;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == tcd_pkg::TCD_ISSUE && cc == tcd_pkg::CC_INVALID)
            |=> (state_reg == tcd_pkg::TCD_IDLE) && (htrans_out == tcd_pkg::HTRANS_IDLE)
                && (hw_dis_reg == cur_hot);
    endproperty
    a_invalid_no_move: assert property (p_invalid_no_move)
        else $error("Invalid structure started a transfer.");

    property p_lane_repeat;
        @(posedge clk_in) disable iff (rst_in)
        (htrans_out == tcd_pkg::HTRANS_NONSEQ && hwrite_out && hsize_out[1] == 1'b0)
            |-> (hwdata_out == repl(hwdata_out, hsize_out[1:0]));
    endproperty
    a_lane_repeat: assert property (p_lane_repeat)
        else $error("Narrow write data not repeated over unused lanes.");

    property p_write_src_width;
        @(posedge clk_in) disable iff (rst_in)
        (htrans_out == tcd_pkg::HTRANS_NONSEQ && hwrite_out) |-> (hsize_out == {1'b0, ssz});
    endproperty
    a_write_src_width: assert property (p_write_src_width)
        else $error("Write size differs from the source width.");

    property p_grant_enabled;
        @(posedge clk_in) disable iff (rst_in)
        (grant_reg != 3'h0) |-> ((grant_reg & en_reg) == grant_reg) && ($onehot(grant_reg));
    endproperty
    a_grant_enabled: assert property (p_grant_enabled)
        else $error("Disabled channel won arbitration.");

    property p_burst_bound;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == tcd_pkg::TCD_STEP) |-> (burst_nx <= limit) && (cnt_nx <= n_elems);
    endproperty
    a_burst_bound: assert property (p_burst_bound)
        else $error("Burst ran past the arbitration limit.");

    property p_wback_clears;
        @(posedge clk_in) disable iff (rst_in)
        (state_reg == tcd_pkg::TCD_WBACK) |=> cfg_we_out
            && (cfg_wdata_out[tcd_pkg::NM1_LSB +: 10] == 10'h0)
            && (cfg_wdata_out[tcd_pkg::CC_LSB +: 3] == tcd_pkg::CC_INVALID);
    endproperty
    a_wback_clears: assert property (p_wback_clears)
        else $error("Completion write-back did not clear count and mode.");

endmodule : tcd_dma

`default_nettype wire

// ### src/tcd_pkg.sv
// Shared constants and types of the three-channel DMA controller.
package tcd_pkg;

    // ==========================================================
    // Channel and configuration memory layout
    // ==========================================================
    localparam int CH_NUM = 3;
    localparam int CFG_AW = 8;
    localparam logic [7:0] CFG_PRI_BASE = 8'h00;
    localparam logic [7:0] CFG_ALT_BASE = 8'h80;
    localparam logic [7:0] CFG_STRIDE = 8'h04;
    localparam logic [2:0] W_SRC = 3'h0;
    localparam logic [2:0] W_DST = 3'h1;
    localparam logic [2:0] W_CTL = 3'h2;
    localparam logic [2:0] FETCH_LAST = 3'h4;
    localparam logic [2:0] FETCH_LAG = 3'h2;

    // ==========================================================
    // Fields of channel_control_word
    // ==========================================================
    localparam int CC_LSB = 0;
    localparam int NM1_LSB = 4;
    localparam int RP_LSB = 14;
    localparam int SINC_LSB = 24;
    localparam int SSZ_LSB = 26;
    localparam int DINC_LSB = 28;
    localparam int DSZ_LSB = 30;
    localparam logic [31:0] CTL_CLR_MASK = 32'h0000_3ff7;
    localparam logic [3:0] RP_MAX = 4'ha;
    localparam logic [10:0] CNT_MAX = 11'h400;
    localparam logic [10:0] CNT_ONE = 11'h001;

    // ==========================================================
    // Cycle-control codes, widths and increments
    // ==========================================================
    localparam logic [2:0] CC_INVALID = 3'h0;
    localparam logic [2:0] CC_BASIC = 3'h1;
    localparam logic [2:0] CC_AUTO = 3'h2;
    localparam logic [2:0] CC_PINGPONG = 3'h3;
    localparam logic [2:0] CC_MSG_PRI = 3'h4;
    localparam logic [2:0] CC_MSG_ALT = 3'h5;
    localparam logic [2:0] CC_PSG_PRI = 3'h6;
    localparam logic [2:0] CC_PSG_ALT = 3'h7;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] INC_NONE = 2'h3;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        TCD_IDLE, TCD_FETCH, TCD_ISSUE, TCD_APH, TCD_DPH, TCD_STEP, TCD_WBACK
    } tcd_state_e;

endpackage : tcd_pkg

// ### tb/tcd_mem_model.sv
// Configuration SRAM and AHB memory that stand at the far side of the DMA controller.
`timescale 1ns/100ps
`default_nettype none
module tcd_mem_model (
    // Clock and slow-answer select.
    input wire logic clk_in,
    input wire logic slow_in,
    // Configuration SRAM.
    input wire logic [7:0] cfg_addr_in,
    input wire logic cfg_we_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic [31:0] cfg_rdata_out,
    // AHB slave.
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hready_out,
    output logic hresp_out
);
    logic [31:0] cfg_mem [256];
    logic [31:0] mem [64];
    logic dph_reg = 1'b0;
    logic wr_reg = 1'b0;
    logic tog_reg = 1'b0;
    logic [31:0] a_reg = 32'h0;
    // Only the lowest 256 bytes exist; anything above answers with an error.
    assign hresp_out = dph_reg & (a_reg[31:8] != 24'h0);
    assign hready_out = ~slow_in | tog_reg;
    // Outside a read data phase the data bus shows a changing, wrong value.
    assign hrdata_out = (dph_reg & ~wr_reg) ? mem[a_reg[7:2]] : ~mem[a_reg[7:2]];
    always @(posedge clk_in) begin
        tog_reg <= ~tog_reg;
        cfg_rdata_out <= cfg_mem[cfg_addr_in];
        if (cfg_we_in) begin
            cfg_mem[cfg_addr_in] <= cfg_wdata_in;
        end
        if (hready_out) begin
            if (dph_reg & wr_reg & ~hresp_out) begin
                mem[a_reg[7:2]] <= hwdata_in;
            end
            dph_reg <= (htrans_in == 2'h2);
            wr_reg <= hwrite_in;
            a_reg <= haddr_in;
        end
    end
endmodule : tcd_mem_model
`default_nettype wire

// ### tb/tcd_dma_tb.sv
// Self-checking bench for the three-channel DMA controller.
`timescale 1ns/100ps
`default_nettype none
module tcd_dma_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic slow = 1'b0;
    logic [2:0] en_set = 3'h0, prio = 3'h0, int_en = 3'h7, preq = 3'h0, sreq = 3'h0, clr = 3'h0;
    logic [2:0] en, dn, fl, ef, id, ie, alt;
    logic [7:0] ca;
    logic cwe, ht_w, rdy, rsp;
    logic [1:0] ht;
    logic [31:0] cwd, crd, ha, hwd, hrd;
    int err_total = 0;
    int n_compared = 0;
    always #10 clk_in = ~clk_in;
    tcd_dma u_dut (.clk_in(clk_in), .rst_in(rst_in), .chan_en_set_in(en_set), .prio_high_in(prio),
        .int_en_in(int_en), .periph_req_in(preq), .sw_req_in(sreq), .alt_clr_in(clr),
        .done_clr_in(clr), .err_clr_in(clr), .chan_en_out(en), .alt_out(alt),
        .channel_complete_flag_out(fl), .err_flag_out(ef), .done_pulse_out(dn),
        .irq_done_out(id), .irq_err_out(ie), .cfg_addr_out(ca), .cfg_we_out(cwe),
        .cfg_wdata_out(cwd), .cfg_rdata_in(crd), .haddr_out(ha), .htrans_out(ht),
        .hwrite_out(ht_w), .hsize_out(), .hwdata_out(hwd), .hrdata_in(hrd), .hready_in(rdy),
        .hresp_in(rsp));
    tcd_mem_model u_mem (.clk_in(clk_in), .slow_in(slow), .cfg_addr_in(ca), .cfg_we_in(cwe),
        .cfg_wdata_in(cwd), .cfg_rdata_out(crd), .haddr_in(ha), .htrans_in(ht),
        .hwrite_in(ht_w), .hwdata_in(hwd), .hrdata_out(hrd), .hready_out(rdy), .hresp_out(rsp));
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask : chk
    task automatic finish_test();
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    function automatic logic [31:0] cw(input logic [2:0] m, input logic [9:0] n,
                                       input logic [3:0] r, input logic [1:0] z);
        return {z, z, z, z, 6'h0, r, n, 1'b0, m};
    endfunction : cw
    task automatic prep(input int c, input logic [31:0] s, input logic [31:0] d,
                        input logic [31:0] w);
        u_mem.cfg_mem[c * 4] = s;
        u_mem.cfg_mem[c * 4 + 1] = d;
        u_mem.cfg_mem[c * 4 + 2] = w;
        @(negedge clk_in);
        en_set[c] = 1'b1;
        clr = 3'h7;
        @(negedge clk_in);
        en_set = 3'h0;
        clr = 3'h0;
    endtask : prep
    task automatic pulse(ref logic [2:0] s, input logic [2:0] v);
        @(negedge clk_in);
        s = v;
        @(negedge clk_in);
        s = 3'h0;
    endtask : pulse
    task automatic wait_done(input int c, input int lim, output logic hit);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clk_in);
            hit = (dn[c] === 1'b1);
        end
        if (hit) begin
            @(negedge clk_in);
            chk(dn[c] === 1'b0, "done pulse longer than one cycle");
        end
    endtask : wait_done
    task automatic need(input int c);
        logic h;
        wait_done(c, 300, h);
        chk(h, "no completion");
        if (!h) finish_test();
    endtask : need
    task automatic t_basic();
        u_mem.mem[0] = 32'h0033_2211;
        prep(0, 32'h0, 32'h40, cw(tcd_pkg::CC_BASIC, 10'h2, 4'ha, tcd_pkg::SZ_BYTE));
        pulse(preq, 3'h1);
        need(0);
        repeat (3) @(negedge clk_in);
        chk(u_mem.mem[16] === 32'h3333_3333, "byte lanes");
        chk(fl[0] === 1'b1 && id[0] === 1'b1, "completion flag");
        chk(en[0] === 1'b0 && u_mem.cfg_mem[2][13:0] === 14'h0, "write-back");
    endtask : t_basic
    task automatic t_pause();
        logic h;
        slow = 1'b1;
        for (int i = 0; i < 3; i++) u_mem.mem[4 + i] = 32'hc0de_0000 + i;
        u_mem.mem[22] = 32'h0;
        prep(1, 32'h10, 32'h50, cw(tcd_pkg::CC_BASIC, 10'h2, 4'h1, 2'h2));
        pulse(preq, 3'h2);
        wait_done(1, 150, h);
        chk(h === 1'b0 && u_mem.mem[22] === 32'h0, "no pause");
        chk(u_mem.mem[21] === 32'hc0de_0001, "first burst");
        pulse(preq, 3'h2);
        need(1);
        chk(u_mem.mem[22] === 32'hc0de_0002, "resume");
        slow = 1'b0;
    endtask : t_pause
    task automatic t_auto();
        u_mem.mem[10] = 32'h5a5a_0003;
        prep(0, 32'h20, 32'h60, cw(tcd_pkg::CC_AUTO, 10'h2, 4'h0, 2'h2));
        pulse(sreq, 3'h1);
        need(0);
        repeat (3) @(negedge clk_in);
        chk(u_mem.mem[26] === 32'h5a5a_0003 && en[0] === 1'b0, "auto request");
    endtask : t_auto
    task automatic t_ping();
        logic h;
        u_mem.cfg_mem[130] = 32'h0;
        prep(0, 32'h0, 32'h78, cw(tcd_pkg::CC_PINGPONG, 10'h0, 4'ha, 2'h2));
        pulse(sreq, 3'h1);
        need(0);
        chk(alt[0] === 1'b1 && en[0] === 1'b1, "no swap to backup");
        pulse(sreq, 3'h1);
        wait_done(0, 60, h);
        chk(h === 1'b0 && en[0] === 1'b0 && alt[0] === 1'b1, "invalid backup ran");
    endtask : t_ping
    task automatic t_fault();
        logic h;
        u_mem.mem[31] = 32'h0;
        prep(2, 32'h0, 32'h7c, cw(tcd_pkg::CC_INVALID, 10'h0, 4'ha, 2'h2));
        pulse(preq, 3'h4);
        wait_done(2, 60, h);
        chk(h === 1'b0 && en[2] === 1'b0 && u_mem.mem[31] === 32'h0, "invalid mode");
        prep(2, 32'h1000, 32'h7c, cw(tcd_pkg::CC_BASIC, 10'h0, 4'ha, 2'h2));
        pulse(preq, 3'h4);
        wait_done(2, 60, h);
        chk(h === 1'b0 && ef[2] === 1'b1 && en[2] === 1'b0, "bus error");
        chk(ie[2] === 1'b1, "error interrupt");
    endtask : t_fault
    task automatic t_prio();
        logic [2:0] first;
        for (int p = 0; p < 2; p++) begin
            prio = (p == 1) ? 3'h2 : 3'h0;
            prep(0, 32'h0, 32'h70, cw(tcd_pkg::CC_BASIC, 10'h0, 4'ha, 2'h2));
            prep(1, 32'h0, 32'h74, cw(tcd_pkg::CC_BASIC, 10'h0, 4'ha, 2'h2));
            pulse(preq, 3'h7);
            first = 3'h0;
            for (int i = 0; i < 200 && first == 3'h0; i++) begin
                @(negedge clk_in);
                first = dn;
            end
            chk(first === ((p == 1) ? 3'h2 : 3'h1), "arbitration order");
            repeat (40) @(negedge clk_in);
            chk(fl === 3'h3, "disabled channel served");
        end
    endtask : t_prio
    initial begin
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst_in = 1'b0;
        t_basic();
        t_pause();
        t_auto();
        t_fault();
        t_ping();
        t_prio();
        finish_test();
    end
endmodule : tcd_dma_tb
`default_nettype wire
